// file: rtl/dpsr_top.v
/*
 * device side core of a two port burst sram with double data rate ports,
 * a shared address bus and echo clocks, run on core_clk.
 * assumes the input clock pair and all pins are asynchronous to core_clk
 * and at least four times slower, so that every half cycle spans several
 * core clocks.
 */
`timescale 1ns/1ns
`include "dpsr_map.vh"

// What this block does
// - rising edges of both input clocks capture inputs and launch read data.
// - echo clocks run free; ECHO_CLK_OUT follows K and ECHO_CLK_OUT_N follows K_N.
// - pll disable held low selects the legacy timing mode.
// - pll enabled: read data appears two and a half cycles after request.
// - legacy mode: read data appears one cycle after request.
// - each access is two beats of 36 bits in one clock cycle.
// - reads and writes start only on a positive clock rising edge.
// - write data registered on rising edges of both input clocks.
// - read data output registers update on rising edges of both clocks.
// - read and write selects registered on positive edge only; byte selects on both clock edges.
// - separate output-only read port and input-only write port.
// - read and write addresses share one multiplexed address bus.
// - read select low starts two-beat read; deselect completes, then tristates.
// - write select low starts a write; deselected port ignores data.
// - read address on positive edge, write address on negative edge.
// - byte selects sampled per beat; each gates a 9-bit lane.
module dpsr_top (
  // core clock and reset
  input  wire                  CORE_CLK,
  input  wire                  RST,
  // input clock pair
  input  wire                  K,
  input  wire                  K_N,
  // mode strap
  input  wire                  PLL_DISABLE_N,
  // port selects
  input  wire                  READ_SELECT_N,
  input  wire                  WRITE_SELECT_N,
  input  wire [`DPSR_BW-1:0]   BYTE_LANE_SELECT_N,
  // shared address and write data
  input  wire [`DPSR_AW-1:0]   ADDR,
  input  wire [`DPSR_DW-1:0]   DATA_IN,
  // read port
  output reg  [`DPSR_DW-1:0]   DATA_OUT,
  output wire                  DATA_OUT_OE_N,
  output reg                   DATA_VALID,
  // echo clocks
  output reg                   ECHO_CLK_OUT,
  output reg                   ECHO_CLK_OUT_N,
  // write buffer overflow
  output reg                   WRITE_DROP
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [`DPSR_SYNC_W-1:0] pin_s2;
  wire [`DPSR_SYNC_W-1:0] pin_s3;

  dpsr_sync #(
    .W (`DPSR_SYNC_W)
  ) u_sync (
    .core_clk (CORE_CLK),
    .rst      (RST),
    .pin_in   ({DATA_IN, ADDR, BYTE_LANE_SELECT_N, WRITE_SELECT_N,
                READ_SELECT_N, PLL_DISABLE_N, K_N, K}),
    .stage2   (pin_s2),
    .stage3   (pin_s3)
  );

  wire                k_s2      = pin_s2[0];
  wire                k_s3      = pin_s3[0];
  wire                kn_s2     = pin_s2[1];
  wire                kn_s3     = pin_s3[1];
  wire                pll_dis_s = pin_s3[2];
  wire                rd_sel_n  = pin_s3[3];
  wire                wr_sel_n  = pin_s3[4];
  wire [`DPSR_BW-1:0] lane_n    = pin_s3[8:5];
  wire [`DPSR_AW-1:0] addr_s    = pin_s3[27:9];
  wire [`DPSR_DW-1:0] din_s     = pin_s3[63:28];

  // ************************************************************
  // edge finding
  // ************************************************************
  reg k_state;
  reg kn_state;
  reg legacy_timing_mode;

  // an edge counts only once stages two and three agree
  wire k_rise  = (k_s2 == k_s3) & k_s3 & ~k_state;
  wire kn_rise = (kn_s2 == kn_s3) & kn_s3 & ~kn_state;
  wire any_edge = k_rise | kn_rise;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      k_state            <= `DPSR_RST_BIT;
      kn_state           <= `DPSR_RST_BIT;
      legacy_timing_mode <= `DPSR_RST_BIT;
      ECHO_CLK_OUT       <= `DPSR_RST_BIT;
      ECHO_CLK_OUT_N     <= `DPSR_RST_BIT;
    end else begin
      if (k_s2 == k_s3) begin
        k_state      <= k_s3;
        ECHO_CLK_OUT <= k_s3;
      end
      if (kn_s2 == kn_s3) begin
        kn_state       <= kn_s3;
        ECHO_CLK_OUT_N <= kn_s3;
      end
      // mode only changes on a positive edge so no burst is split
      if (k_rise) begin
        legacy_timing_mode <= ~pll_dis_s;
      end
    end
  end

  // ************************************************************
  // lane merge
  // ************************************************************
  function [`DPSR_DW-1:0] lane_merge;
    input [`DPSR_DW-1:0] old_word;
    input [`DPSR_DW-1:0] new_word;
    input [`DPSR_BW-1:0] sel_n;
    integer i;
    begin
      lane_merge = old_word;
      for (i = 0; i < `DPSR_BW; i = i + 1) begin
        if (!sel_n[i]) begin
          lane_merge[i*`DPSR_LANE +: `DPSR_LANE] =
            new_word[i*`DPSR_LANE +: `DPSR_LANE];
        end
      end
    end
  endfunction

  // ************************************************************
  // write port capture
  // ************************************************************
  reg                 wr_active;
  reg [`DPSR_DW-1:0]  wr_beat0;
  reg [`DPSR_BW-1:0]  wr_lane0;
  reg                 wr_push;
  reg [`DPSR_FIFO_W-1:0] wr_entry;
  wire                fifo_in_ready;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      wr_active  <= `DPSR_RST_BIT;
      wr_beat0   <= `DPSR_RST_DATA;
      wr_lane0   <= {`DPSR_BW{1'b1}};
      wr_push    <= `DPSR_RST_BIT;
      wr_entry   <= {`DPSR_FIFO_W{1'b0}};
      WRITE_DROP <= `DPSR_RST_BIT;
    end else begin
      wr_push    <= 1'b0;
      WRITE_DROP <= 1'b0;
      if (k_rise) begin
        // deselected port leaves data and lanes untouched
        wr_active <= ~wr_sel_n;
        if (!wr_sel_n) begin
          wr_beat0 <= din_s;
          wr_lane0 <= lane_n;
        end
      end else if (kn_rise && wr_active) begin
        wr_active <= 1'b0;
        // address and second beat taken on the negative edge
        wr_entry  <= {addr_s, din_s, wr_beat0, lane_n, wr_lane0};
        wr_push   <= 1'b1;
      end
      if (wr_push && !fifo_in_ready) begin
        WRITE_DROP <= 1'b1;
      end
    end
  end

  // ************************************************************
  // write buffer
  // ************************************************************
  wire                   fifo_out_valid;
  wire [`DPSR_FIFO_W-1:0] fifo_out_data;
  reg                    rd_fetch;
  wire                   drain_ready = ~rd_fetch;

  dpsr_fifo #(
    .W  (`DPSR_FIFO_W),
    .D  (`DPSR_FIFO_DEPTH),
    .AW (`DPSR_FIFO_AW)
  ) u_fifo (
    .core_clk  (CORE_CLK),
    .rst       (RST),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_entry),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  // ************************************************************
  // memory array
  // ************************************************************
  reg [2*`DPSR_DW-1:0] mem [0:`DPSR_WORDS-1];

  wire [`DPSR_AW-1:0] dr_addr  = fifo_out_data[98:80];
  wire [`DPSR_DW-1:0] dr_beat1 = fifo_out_data[79:44];
  wire [`DPSR_DW-1:0] dr_beat0 = fifo_out_data[43:8];
  wire [`DPSR_BW-1:0] dr_lane1 = fifo_out_data[7:4];
  wire [`DPSR_BW-1:0] dr_lane0 = fifo_out_data[3:0];
  wire [2*`DPSR_DW-1:0] dr_old = mem[dr_addr];

  // read fetches own the array; draining waits one core cycle then
  always @(posedge CORE_CLK) begin
    if (fifo_out_valid && drain_ready) begin
      mem[dr_addr] <= {lane_merge(dr_old[71:36], dr_beat1, dr_lane1),
                       lane_merge(dr_old[35:0], dr_beat0, dr_lane0)};
    end
  end

  // ************************************************************
  // read request and pipeline
  // ************************************************************
  reg [`DPSR_AW-1:0]  rd_addr;
  reg [`DPSR_PIPE-1:0] pipe_v;
  reg [`DPSR_DW-1:0]  pipe_d [0:`DPSR_PIPE-1];
  reg                 hold_v;
  reg [`DPSR_DW-1:0]  hold_d;
  reg                 out_v;
  integer             j;

  // tap where a beat inserted after edge e is due at edge e + latency
  wire [2:0] tap_data  = legacy_timing_mode ? 3'h1 : 3'h4;
  wire [2:0] tap_valid = legacy_timing_mode ? 3'h0 : 3'h3;
  wire [2*`DPSR_DW-1:0] rd_word = mem[rd_addr];

  always @(posedge CORE_CLK) begin
    if (RST) begin
      rd_fetch <= `DPSR_RST_BIT;
      rd_addr  <= {`DPSR_AW{1'b0}};
      pipe_v   <= {`DPSR_PIPE{1'b0}};
      hold_v   <= `DPSR_RST_BIT;
      hold_d   <= `DPSR_RST_DATA;
      out_v    <= `DPSR_RST_BIT;
      DATA_OUT <= `DPSR_RST_DATA;
      DATA_VALID <= `DPSR_RST_BIT;
      for (j = 0; j < `DPSR_PIPE; j = j + 1) begin
        pipe_d[j] <= `DPSR_RST_DATA;
      end
    end else begin
      rd_fetch <= 1'b0;
      if (any_edge) begin
        // output registers move on both clock edges
        DATA_OUT   <= pipe_d[tap_data];
        out_v      <= pipe_v[tap_data];
        DATA_VALID <= pipe_v[tap_valid];
        for (j = `DPSR_PIPE - 1; j > 0; j = j - 1) begin
          pipe_d[j] <= pipe_d[j-1];
        end
        pipe_v <= {pipe_v[`DPSR_PIPE-2:0], 1'b0};
        if (kn_rise) begin
          // second beat follows the first half a cycle later
          pipe_v[0] <= hold_v;
          pipe_d[0] <= hold_d;
          hold_v    <= 1'b0;
        end
      end
      if (k_rise && !rd_sel_n) begin
        rd_fetch <= 1'b1;
        rd_addr  <= addr_s;
      end
      if (rd_fetch) begin
        // first beat is the low half of the location
        pipe_v[0] <= 1'b1;
        pipe_d[0] <= rd_word[35:0];
        hold_v    <= 1'b1;
        hold_d    <= rd_word[71:36];
      end
    end
  end

  // output only read port; enable drops once the last beat has gone
  assign DATA_OUT_OE_N = ~out_v;

endmodule // dpsr_top

// file: rtl/dpsr_map.vh
/*
 * constants of the dual port double data rate burst sram core: widths,
 * read latencies counted in input clock half cycles, fifo depth, resets.
 * assumes nothing; definitions only.
 */
`ifndef DPSR_MAP_VH
`define DPSR_MAP_VH

// ************************************************************
// widths
// ************************************************************
`define DPSR_DW          36
`define DPSR_AW          19
`define DPSR_BW          4
`define DPSR_LANE        9
`define DPSR_WORDS       524288
`define DPSR_SYNC_W      64

// ************************************************************
// timing: latencies in half cycles of the input clock pair, legacy limit in MHz
// ************************************************************
`define DPSR_LAT_NORM    5
`define DPSR_LAT_LEGACY  2
`define DPSR_PIPE        5
`define DPSR_LEGACY_MHZ  167

// ************************************************************
// write buffer
// ************************************************************
`define DPSR_FIFO_DEPTH  16
`define DPSR_FIFO_AW     4
`define DPSR_FIFO_W      99

// ************************************************************
// reset values
// ************************************************************
`define DPSR_RST_BIT     1'h0
`define DPSR_RST_DATA    36'h000000000

`endif

// file: rtl/dpsr_sync.v
/*
 * three stage synchroniser for a bundle of pins.
 * assumes the pins are asynchronous to core_clk; callers compare the
 * second and third stages only.
 */
`timescale 1ns/1ns

module dpsr_sync #(
  parameter W = 64
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rst,
  // pins
  input  wire [W-1:0] pin_in,
  // stages two and three
  output reg  [W-1:0] stage2,
  output reg  [W-1:0] stage3
);

  reg [W-1:0] stage1;

  // ************************************************************
  // shift chain
  // ************************************************************
  always @(posedge core_clk) begin
    if (rst) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

endmodule // dpsr_sync

// file: rtl/dpsr_fifo.v
/*
 * synchronous fifo with valid and ready on both sides.
 * assumes one clock; depth is a power of two equal to 2**AW.
 */
`timescale 1ns/1ns

module dpsr_fifo #(
  parameter W  = 99,
  parameter D  = 16,
  parameter AW = 4
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rst,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // ************************************************************
  // pointers and storage
  // ************************************************************
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // dpsr_fifo

// file: dv/dpsr_top_sva.sv
/* checker on the block's ports: echo clocks, read burst shape, read latency.
   assumes a k half period spans four core clocks; bound to dpsr_top below. */
`timescale 1ns/1ns
`include "dpsr_map.vh"
module dpsr_top_sva (
  // clocks and reset
  input wire                CORE_CLK,
  input wire                RST,
  input wire                K,
  input wire                K_N,
  // controls
  input wire                PLL_DISABLE_N,
  input wire                READ_SELECT_N,
  input wire                WRITE_SELECT_N,
  input wire [`DPSR_BW-1:0] BYTE_LANE_SELECT_N,
  input wire [`DPSR_AW-1:0] ADDR,
  input wire [`DPSR_DW-1:0] DATA_IN,
  // outputs
  input wire [`DPSR_DW-1:0] DATA_OUT,
  input wire                DATA_OUT_OE_N,
  input wire                DATA_VALID,
  input wire                ECHO_CLK_OUT,
  input wire                ECHO_CLK_OUT_N,
  input wire                WRITE_DROP
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  // ********
  // sequences
  // ********
  sequence s_rd_req;
    $rose(K) && !READ_SELECT_N;
  endsequence
  sequence s_burst;
    $fell(DATA_OUT_OE_N) ##1 !DATA_OUT_OE_N [*7];
  endsequence
  // windows cover 3 to 4 core clocks of edge detection
  AST_ECHO_K: assert property ($rose(K) |-> ##[1:6] $rose(ECHO_CLK_OUT))
    else $error("echo clock missed a k rise");
  AST_ECHO_KN: assert property ($rose(K_N) |-> ##[1:6] $rose(ECHO_CLK_OUT_N))
    else $error("inverse echo clock missed a k_n rise");
  AST_RD_NORM: assert property (s_rd_req ##0 PLL_DISABLE_N |-> ##[20:25] !DATA_OUT_OE_N)
    else $error("normal read beat late");
  AST_RD_LEGACY: assert property (s_rd_req ##0 !PLL_DISABLE_N |-> ##[8:13] !DATA_OUT_OE_N)
    else $error("legacy read beat late");
  AST_VALID_THEN_DATA: assert property ($rose(DATA_VALID) |-> ##[3:5] s_burst)
    else $error("valid not followed by a two beat burst");
  AST_VALID_LEADS: assert property ($fell(DATA_OUT_OE_N) |-> DATA_VALID && $past(DATA_VALID, 3))
    else $error("beat driven without valid lead");
  AST_OE_BURST: assert property ($fell(DATA_OUT_OE_N) |=> !DATA_OUT_OE_N [*7])
    else $error("read burst shorter than two beats");
  AST_VALID_BURST: assert property ($rose(DATA_VALID) |=> DATA_VALID [*7])
    else $error("valid dropped inside a burst");
  AST_DOUT_STANDS: assert property ($changed(DATA_OUT) |=> $stable(DATA_OUT) [*3])
    else $error("read data changed between input clock edges");
endmodule // dpsr_top_sva

bind dpsr_top dpsr_top_sva i_sva (.CORE_CLK(CORE_CLK), .RST(RST), .K(K), .K_N(K_N),
  .PLL_DISABLE_N(PLL_DISABLE_N), .READ_SELECT_N(READ_SELECT_N), .WRITE_SELECT_N(WRITE_SELECT_N),
  .BYTE_LANE_SELECT_N(BYTE_LANE_SELECT_N), .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
  .DATA_OUT_OE_N(DATA_OUT_OE_N), .DATA_VALID(DATA_VALID), .ECHO_CLK_OUT(ECHO_CLK_OUT),
  .ECHO_CLK_OUT_N(ECHO_CLK_OUT_N), .WRITE_DROP(WRITE_DROP));

// file: dv/dpsr_ctrl_model.sv
/* memory controller model: input clock pair, selects, lanes, address, write data;
   captures read beats on echo clock edges. assumes core_clk is the block's clock. */
`timescale 1ns/1ns
module dpsr_ctrl_model (
  // sampling side
  input  wire         core_clk,
  input  wire  [35:0] data_out,
  input  wire         data_out_oe_n,
  input  wire         echo_clk_out,
  // pins toward the block
  output logic        k,
  output logic        k_n,
  output logic        pll_disable_n,
  output logic        read_select_n,
  output logic        write_select_n,
  output logic [3:0]  byte_lane_select_n,
  output logic [18:0] addr,
  output logic [35:0] data_in
);
  realtime     t_req;
  realtime     time_q[$];
  logic [35:0] beat_q[$];
  logic        echo_seen;
  initial begin
    k = 1'h0;
    k_n = 1'h1;
    addr = 19'h0;
    data_in = 36'h0;
    byte_lane_select_n = 4'hF;
    read_select_n = 1'h1;
    write_select_n = 1'h1;
    pll_disable_n = 1'h1;
    // 160 ns period, far below the legacy limit; odd start keeps it off the core phase
    #7;
    forever begin
      #80;
      k = ~k;
      k_n = ~k;
    end
  end
  task automatic align;
    @(posedge k_n);
    #40;
  endtask
  // one k cycle; pins move mid half period, ignored pins show inverted junk
  task automatic cyc(input logic rd, input logic [18:0] ra, input logic wr,
      input logic [18:0] wa, input logic [35:0] d0, input logic [35:0] d1,
      input logic [3:0] l0, input logic [3:0] l1, input logic m);
    read_select_n = ~rd;
    write_select_n = ~wr;
    pll_disable_n = m;
    addr = rd ? ra : ~addr;
    data_in = wr ? d0 : ~data_in;
    byte_lane_select_n = wr ? l0 : ~byte_lane_select_n;
    @(posedge k);
    t_req = $realtime;
    #40;
    read_select_n = 1'h1;
    write_select_n = 1'h1;
    addr = wr ? wa : ~addr;
    data_in = wr ? d1 : ~data_in;
    byte_lane_select_n = wr ? l1 : ~byte_lane_select_n;
    @(posedge k_n);
    #40;
  endtask
  // capture one core clock after an echo edge, mid beat
  always @(posedge core_clk) begin
    echo_seen <= echo_clk_out;
    if (echo_seen !== echo_clk_out && data_out_oe_n === 1'h0) begin
      beat_q.push_back(data_out);
      time_q.push_back($realtime);
    end
  end
endmodule // dpsr_ctrl_model

// file: dv/dpsr_top_tb.sv
/* top bench: block and controller model; directed scenarios, write buffer seen through the block.
   assumes the model drives every input pin of the block except CORE_CLK and RST. */
`timescale 1ns/1ns
`include "dpsr_map.vh"
module dpsr_top_tb;
  logic                CORE_CLK;
  logic                RST;
  wire                 k, k_n, pdn, rsn, wsn, oen, dv, eck, eckn, wdrop;
  wire [`DPSR_BW-1:0]  lsn;
  wire [`DPSR_AW-1:0]  addr;
  wire [`DPSR_DW-1:0]  din, dout;
  int                  n_fail, tests_run;
  int                  n_drop = 0;
  int                  n_vld = 0;
  int                  n_eckn = 0;
  logic                dv_q, eckn_q;
  dpsr_top i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .K(k), .K_N(k_n), .PLL_DISABLE_N(pdn),
    .READ_SELECT_N(rsn), .WRITE_SELECT_N(wsn), .BYTE_LANE_SELECT_N(lsn), .ADDR(addr),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OUT_OE_N(oen), .DATA_VALID(dv), .ECHO_CLK_OUT(eck),
    .ECHO_CLK_OUT_N(eckn), .WRITE_DROP(wdrop));
  dpsr_ctrl_model i_ctrl (.core_clk(CORE_CLK), .data_out(dout), .data_out_oe_n(oen),
    .echo_clk_out(eck), .k(k), .k_n(k_n), .pll_disable_n(pdn), .read_select_n(rsn),
    .write_select_n(wsn), .byte_lane_select_n(lsn), .addr(addr), .data_in(din));
  // running counts of drop pulses, valid rises and inverse echo rises
  always @(posedge CORE_CLK) begin
    dv_q <= dv;
    eckn_q <= eckn;
    if (wdrop === 1'h1) n_drop <= n_drop + 1;
    if (dv === 1'h1 && dv_q === 1'h0) n_vld <= n_vld + 1;
    if (eckn === 1'h1 && eckn_q === 1'h0) n_eckn <= n_eckn + 1;
  end
  // ********
  // helpers
  // ********
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [35:0] mix(input logic [35:0] o, input logic [35:0] n,
      input logic [3:0] s);
    mix = o;
    for (int i = 0; i < 4; i++) begin
      if (!s[i]) mix[9*i +: 9] = n[9*i +: 9];
    end
  endfunction
  task automatic wr(input logic [18:0] a, input logic [35:0] d0, input logic [35:0] d1,
      input logic [3:0] l0, input logic [3:0] l1, input logic m);
    i_ctrl.cyc(1'h0, ~a, 1'h1, a, d0, d1, l0, l1, m);
  endtask
  // read a with an optional write alongside, then five quiet cycles
  task automatic rd_chk(input logic [18:0] a, input logic [35:0] lo, input logic [35:0] hi,
      input logic m, input logic w, input logic [18:0] wa, input logic [35:0] w0);
    realtime t0;
    realtime dt;
    i_ctrl.beat_q.delete();
    i_ctrl.time_q.delete();
    i_ctrl.cyc(1'h1, a, w, wa, w0, ~w0, 4'h0, 4'h0, m);
    t0 = i_ctrl.t_req;
    repeat (5) i_ctrl.cyc(1'h0, a, 1'h0, wa, w0, w0, 4'h0, 4'h0, m);
    check("beat count", 36'(i_ctrl.beat_q.size()), 36'h2);
    if (i_ctrl.beat_q.size() == 2) begin
      dt = i_ctrl.time_q[0] - t0 - (m ? `DPSR_LAT_NORM : `DPSR_LAT_LEGACY) * 80;
      check("low beat", i_ctrl.beat_q[0], lo);
      check("high beat", i_ctrl.beat_q[1], hi);
      check("beat0 delay", 36'(dt > 50 && dt < 130), 36'h1);
    end
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_rw;
    wr(19'h00123, 36'h111111111, 36'h222222222, 4'h0, 4'h0, 1'h1);
    rd_chk(19'h00123, 36'h111111111, 36'h222222222, 1'h1, 1'h1, 19'h7FFFF, 36'hC0FFEE123);
    rd_chk(19'h7FFFF, 36'hC0FFEE123, 36'h3F0011EDC, 1'h1, 1'h0, 19'h0, 36'h0);
    $display("read write test done");
  endtask
  task automatic t_lanes;
    wr(19'h0ABCD, 36'hAAAAAAAAA, 36'h555555555, 4'h0, 4'h0, 1'h1);
    wr(19'h0ABCD, 36'h123456789, 36'h9ABCDEF01, 4'h5, 4'hA, 1'h1);
    rd_chk(19'h0ABCD, mix(36'hAAAAAAAAA, 36'h123456789, 4'h5),
      mix(36'h555555555, 36'h9ABCDEF01, 4'hA), 1'h1, 1'h0, 19'h0, 36'h0);
    $display("byte lane test done");
  endtask
  task automatic t_legacy;
    // the array has no reset, so clear the word before the partial write
    wr(19'h40000, 36'h0, 36'h0, 4'h0, 4'h0, 1'h0);
    wr(19'h40000, 36'hF0F0F0F0F, 36'h0F0F0F0F0, 4'hE, 4'h0, 1'h0);
    rd_chk(19'h40000, mix(36'h0, 36'hF0F0F0F0F, 4'hE), 36'h0F0F0F0F0, 1'h0, 1'h0, 19'h0,
      36'h0);
    rd_chk(19'h00123, 36'h111111111, 36'h222222222, 1'h1, 1'h0, 19'h0, 36'h0);
    $display("legacy mode test done");
  endtask
  // sixteen back to back writes through the buffer, then every fifth word read back
  task automatic t_fifo;
    int          dr0;
    int          ec0;
    int          vl0;
    logic [35:0] w;
    dr0 = n_drop;
    ec0 = n_eckn;
    for (int i = 0; i < 16; i++) begin
      w = 36'hA50000000 + 36'(i);
      wr(19'h01000 + 19'(i), w, ~w, 4'h0, 4'h0, 1'h1);
      check("drop count", 36'(n_drop - dr0), 36'h0);
    end
    check("inverse echo rises", 36'(n_eckn - ec0), 36'h10);
    check("drop pin", 36'(wdrop), 36'h0);
    vl0 = n_vld;
    for (int i = 0; i < 16; i += 5) begin
      w = 36'hA50000000 + 36'(i);
      rd_chk(19'h01000 + 19'(i), w, ~w, 1'h1, 1'h0, 19'h0, 36'h0);
    end
    check("valid bursts", 36'(n_vld - vl0), 36'h4);
    check("read port idle", 36'(oen), 36'h1);
    $display("buffer test done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    CORE_CLK = 1'h0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #1500000;
    n_fail++;
    $display("MISMATCH run length expected end seen hang");
    tally_and_finish;
  end
  initial begin
    RST = 1'h1;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge CORE_CLK);
    #2;
    RST = 1'h0;
    i_ctrl.align();
    repeat (3) i_ctrl.cyc(1'h0, 19'h0, 1'h0, 19'h0, 36'h0, 36'h0, 4'hF, 4'hF, 1'h1);
    t_rw;
    t_lanes;
    t_legacy;
    t_fifo;
    tally_and_finish;
  end
endmodule // dpsr_top_tb
